// [verilog/vbd_pkg.sv]
// Shared constants and types for the blanking-data readback bank
package vbd_pkg;

  // ****************************************************************
  // Serial bus subaddresses
  // ****************************************************************
  localparam logic [7:0] VBD_ADDR_FLAG_CLEAR = 8'h1F;
  localparam logic [7:0] VBD_ADDR_FLAGS = 8'h21;
  localparam logic [7:0] VBD_ADDR_CC_ODD_LO = 8'h22;
  localparam logic [7:0] VBD_ADDR_CC_ODD_HI = 8'h23;
  localparam logic [7:0] VBD_ADDR_CC_EVEN_LO = 8'h24;
  localparam logic [7:0] VBD_ADDR_CC_EVEN_HI = 8'h25;
  localparam logic [7:0] VBD_ADDR_CG_ODD_B0 = 8'h26;
  localparam logic [7:0] VBD_ADDR_CG_ODD_B1 = 8'h27;
  localparam logic [7:0] VBD_ADDR_CG_ODD_N2 = 8'h28;
  localparam logic [7:0] VBD_ADDR_CG_EVEN_B0 = 8'h29;
  localparam logic [7:0] VBD_ADDR_CG_EVEN_B1 = 8'h2A;
  localparam logic [7:0] VBD_ADDR_CG_EVEN_N2 = 8'h2B;
  localparam logic [7:0] VBD_ADDR_WS_LO = 8'h2C;
  localparam logic [7:0] VBD_ADDR_WS_HI = 8'h2D;

  // ****************************************************************
  // Device address on the serial bus (value is arbitrary)
  // ****************************************************************
  localparam logic [6:0] VBD_DEV_ADDR = 7'h21;

  // ****************************************************************
  // Capture slots and their flag bit positions
  // ****************************************************************
  localparam int VBD_SLOTS = 5;
  localparam int VBD_SLOT_CC_ODD = 0;
  localparam int VBD_SLOT_CC_EVEN = 1;
  localparam int VBD_SLOT_CG_ODD = 2;
  localparam int VBD_SLOT_CG_EVEN = 3;
  localparam int VBD_SLOT_WS = 4;
  localparam int VBD_FLAG_CC_ODD = 6;
  localparam int VBD_FLAG_CC_EVEN = 5;
  localparam int VBD_FLAG_CG_ODD = 4;
  localparam int VBD_FLAG_CG_EVEN = 3;
  localparam int VBD_FLAG_WS = 0;

  // ****************************************************************
  // Word widths as masks
  // ****************************************************************
  localparam int VBD_WORD_W = 20;
  localparam logic [19:0] VBD_MASK_CC = 20'h0FFFF;
  localparam logic [19:0] VBD_MASK_CG = 20'hFFFFF;
  localparam logic [19:0] VBD_MASK_WS = 20'h01FFF;
  localparam logic [3:0] VBD_BITS_PER_BYTE = 4'h8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic stb;
    logic [VBD_WORD_W-1:0] word;
  } vbd_cap_t;

  typedef enum logic [3:0] {
    VBD_IDLE,
    VBD_ADDR,
    VBD_ADDR_ACK,
    VBD_SUB,
    VBD_SUB_ACK,
    VBD_WDATA,
    VBD_WDATA_ACK,
    VBD_RDATA,
    VBD_RDATA_ACK
  } vbd_state_t;

  function automatic logic [19:0] vbd_slot_mask(input int idx);
    if (idx == VBD_SLOT_WS)
      return VBD_MASK_WS;
    else if (idx == VBD_SLOT_CG_ODD || idx == VBD_SLOT_CG_EVEN)
      return VBD_MASK_CG;
    else
      return VBD_MASK_CC;
  endfunction

  function automatic int vbd_slot_flag(input int idx);
    if (idx == VBD_SLOT_CC_ODD)
      return VBD_FLAG_CC_ODD;
    else if (idx == VBD_SLOT_CC_EVEN)
      return VBD_FLAG_CC_EVEN;
    else if (idx == VBD_SLOT_CG_ODD)
      return VBD_FLAG_CG_ODD;
    else if (idx == VBD_SLOT_CG_EVEN)
      return VBD_FLAG_CG_EVEN;
    else
      return VBD_FLAG_WS;
  endfunction

endpackage

// [verilog/vbd_slot.sv]
// One capture buffer with its presence flag
`timescale 1ns/1ps
module vbd_slot
  import vbd_pkg::*;
#(
  parameter logic [19:0] MASK = 20'hFFFFF
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Detector side
  input wire vbd_cap_t cap,
  // Host side
  input wire logic clr,
  output logic [VBD_WORD_W-1:0] word,
  output logic flag
);

  logic [VBD_WORD_W-1:0] word_r;
  logic flag_r;
  wire flag_nxt = cap.stb | (flag_r & ~clr);

  // Buffer has no reset value; undefined bits forced low
  always_ff @(posedge core_clk)
  begin
    if (cap.stb)
      word_r <= cap.word & MASK;
  end

  // Capture wins over a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign word = word_r;
  assign flag = flag_r;

endmodule // vbd_slot

// [verilog/vbd_bank.sv]
// Blanking-data readback bank with its serial control bus slave
`timescale 1ns/1ps
module vbd_bank
  import vbd_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = VBD_DEV_ADDR
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Detector captures, one per item
  input wire vbd_cap_t [VBD_SLOTS-1:0] cap,
  // Serial control bus, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  function automatic logic [7:0] vbd_read_mux(
    input logic [7:0] addr,
    input logic [7:0] flags,
    input logic [VBD_SLOTS*VBD_WORD_W-1:0] words
  );
    logic [VBD_WORD_W-1:0] cco;
    logic [VBD_WORD_W-1:0] cce;
    logic [VBD_WORD_W-1:0] cgo;
    logic [VBD_WORD_W-1:0] cge;
    logic [VBD_WORD_W-1:0] ws;
    cco = words[VBD_SLOT_CC_ODD*VBD_WORD_W +: VBD_WORD_W];
    cce = words[VBD_SLOT_CC_EVEN*VBD_WORD_W +: VBD_WORD_W];
    cgo = words[VBD_SLOT_CG_ODD*VBD_WORD_W +: VBD_WORD_W];
    cge = words[VBD_SLOT_CG_EVEN*VBD_WORD_W +: VBD_WORD_W];
    ws = words[VBD_SLOT_WS*VBD_WORD_W +: VBD_WORD_W];
    if (addr == VBD_ADDR_FLAGS)
      return flags;
    else if (addr == VBD_ADDR_CC_ODD_LO)
      return cco[7:0];
    else if (addr == VBD_ADDR_CC_ODD_HI)
      return cco[15:8];
    else if (addr == VBD_ADDR_CC_EVEN_LO)
      return cce[7:0];
    else if (addr == VBD_ADDR_CC_EVEN_HI)
      return cce[15:8];
    else if (addr == VBD_ADDR_CG_ODD_B0)
      return cgo[7:0];
    else if (addr == VBD_ADDR_CG_ODD_B1)
      return cgo[15:8];
    else if (addr == VBD_ADDR_CG_ODD_N2)
      return {4'h0, cgo[19:16]};
    else if (addr == VBD_ADDR_CG_EVEN_B0)
      return cge[7:0];
    else if (addr == VBD_ADDR_CG_EVEN_B1)
      return cge[15:8];
    else if (addr == VBD_ADDR_CG_EVEN_N2)
      return {4'h0, cge[19:16]};
    else if (addr == VBD_ADDR_WS_LO)
      return ws[7:0];
    else if (addr == VBD_ADDR_WS_HI)
      return {3'h0, ws[12:8]};
    else
      return 8'h00;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  vbd_state_t state_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [3:0] cnt_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic nack_r;
  logic sda_oe_r;
  logic sda_out_r;
  logic clr_stb_r;
  logic [7:0] clr_bits_r;
  logic [VBD_SLOTS-1:0] slot_flag;
  logic [VBD_SLOTS*VBD_WORD_W-1:0] slot_words;
  logic [7:0] flag_byte;

  // ****************************************************************
  // Capture slots
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < VBD_SLOTS; gi = gi + 1)
    begin : g_slot
      vbd_slot #(
        .MASK(vbd_slot_mask(gi))
      ) u_slot (
        .core_clk(core_clk),
        .rst(rst),
        .cap(cap[gi]),
        .clr(clr_stb_r & clr_bits_r[vbd_slot_flag(gi)]),
        .word(slot_words[gi*VBD_WORD_W +: VBD_WORD_W]),
        .flag(slot_flag[gi])
      );
    end
  endgenerate

  assign flag_byte = {1'b0,
                      slot_flag[VBD_SLOT_CC_ODD],
                      slot_flag[VBD_SLOT_CC_EVEN],
                      slot_flag[VBD_SLOT_CG_ODD],
                      slot_flag[VBD_SLOT_CG_EVEN],
                      2'b00,
                      slot_flag[VBD_SLOT_WS]};

  // ****************************************************************
  // Bus condition decode
  // ****************************************************************
  wire scl_rise = scl_in & ~scl_d_r;
  wire scl_fall = ~scl_in & scl_d_r;
  wire bus_start = scl_in & scl_d_r & sda_d_r & ~sda_in;
  wire bus_stop = scl_in & scl_d_r & ~sda_d_r & sda_in;
  wire byte_full = (cnt_r == VBD_BITS_PER_BYTE);
  wire addr_hit = (rx_r[7:1] == DEV_ADDR);
  wire [7:0] rd_byte = vbd_read_mux(ptr_r, flag_byte, slot_words);
  wire is_clear_wr = (ptr_r == VBD_ADDR_FLAG_CLEAR);
  wire rx_state = (state_r == VBD_ADDR) || (state_r == VBD_SUB) ||
                  (state_r == VBD_WDATA) || (state_r == VBD_RDATA);

  // ****************************************************************
  // Line history
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
    end
  end

  // ****************************************************************
  // Bit counter and receive shifter
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_r <= 8'h00;
      cnt_r <= 4'h0;
      nack_r <= 1'b0;
    end
    else if (bus_start)
      cnt_r <= 4'h0;
    else if (scl_rise && rx_state)
    begin
      rx_r <= {rx_r[6:0], sda_in};
      cnt_r <= cnt_r + 4'h1;
    end
    else if (scl_rise && state_r == VBD_RDATA_ACK)
      nack_r <= sda_in;
    else if (scl_fall && !rx_state)
      cnt_r <= 4'h0;
  end

  // ****************************************************************
  // Flag clear strobe, one cycle per byte written to the clear register
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clr_stb_r <= 1'b0;
      clr_bits_r <= 8'h00;
    end
    else
    begin
      clr_stb_r <= scl_fall && state_r == VBD_WDATA && byte_full && is_clear_wr;
      clr_bits_r <= rx_r;
    end
  end

  // ****************************************************************
  // Protocol state machine
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= VBD_IDLE;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
    end
    else if (bus_start)
    begin
      state_r <= VBD_ADDR;
      sda_oe_r <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_r <= VBD_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (scl_fall)
    begin
      case (state_r)
        VBD_ADDR:
          if (byte_full)
          begin
            if (addr_hit)
            begin
              state_r <= VBD_ADDR_ACK;
              rw_r <= rx_r[0];
              sda_oe_r <= 1'b1;
            end
            else
              state_r <= VBD_IDLE;
          end
        VBD_ADDR_ACK:
          if (rw_r)
          begin
            state_r <= VBD_RDATA;
            tx_r <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
            ptr_r <= ptr_r + 8'h01;
          end
          else
          begin
            state_r <= VBD_SUB;
            sda_oe_r <= 1'b0;
          end
        VBD_SUB:
          if (byte_full)
          begin
            state_r <= VBD_SUB_ACK;
            ptr_r <= rx_r;
            sda_oe_r <= 1'b1;
          end
        VBD_SUB_ACK:
        begin
          state_r <= VBD_WDATA;
          sda_oe_r <= 1'b0;
        end
        VBD_WDATA:
          if (byte_full)
          begin
            // Only the clear register acts; buffer writes are dropped
            state_r <= VBD_WDATA_ACK;
            ptr_r <= ptr_r + 8'h01;
            sda_oe_r <= 1'b1;
          end
        VBD_WDATA_ACK:
        begin
          state_r <= VBD_WDATA;
          sda_oe_r <= 1'b0;
        end
        VBD_RDATA:
          if (byte_full)
          begin
            state_r <= VBD_RDATA_ACK;
            sda_oe_r <= 1'b0;
          end
          else
          begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        VBD_RDATA_ACK:
          if (!nack_r)
          begin
            state_r <= VBD_RDATA;
            tx_r <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
            ptr_r <= ptr_r + 8'h01;
          end
          else
          begin
            state_r <= VBD_IDLE;
            sda_oe_r <= 1'b0;
          end
        default:
          sda_oe_r <= 1'b0;
      endcase
    end
  end

  assign sda_oe = sda_oe_r;
  assign sda_out = sda_out_r;

endmodule // vbd_bank

// [testbench/vbd_host_model.sv]
// Serial bus host model
`timescale 1ns/1ps
module vbd_host_model
#(
  parameter int HALF = 4
)
(
  // Clock
  input wire logic core_clk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hw();
    repeat (HALF) @(negedge core_clk);
  endtask

  // Start, also the repeated start
  task automatic start();
    sda_low = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sda_low = 1'b1;
    hw();
    scl = 1'b0;
    hw();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sda_low = 1'b0;
    hw();
  endtask

  // Eight bits then the acknowledge bit, sampled mid-high
  task automatic xb(input logic [7:0] d, input logic mack, output logic [7:0] q,
                    output logic ack);
    logic [8:0] b;
    b = {d, mack};
    for (int i = 8; i >= 0; i--)
    begin
      sda_low = ~b[i];
      hw();
      scl = 1'b1;
      repeat (HALF / 2) @(negedge core_clk);
      if (i > 0)
        q[i-1] = sda;
      else
        ack = sda;
      repeat (HALF / 2) @(negedge core_clk);
      scl = 1'b0;
    end
    hw();
  endtask
endmodule // vbd_host_model

// [testbench/vbd_bank_sva.sv]
// Concurrent checks on the bank's serial pins
`timescale 1ns/1ps
module vbd_bank_sva
  import vbd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Captures
  input wire vbd_cap_t [VBD_SLOTS-1:0] cap,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_out_low;
    !sda_out;
  endproperty
  a_out_low: assert property (p_out_low) else $error("sda_out high");
  property p_rel;
    $fell(rst) |-> !sda_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("oe after reset");
  property p_chg;
    $changed(sda_oe) && !$past(rst) |-> !scl_in;
  endproperty
  a_chg: assert property (p_chg) else $error("oe moved, scl high");
  property p_stab;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_stab: assert property (p_stab) else $error("oe unstable");
  property p_quiet;
    scl_in && $past(scl_in) && $fell(sda_in) |=> !sda_oe [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("oe after start");
  property p_stop;
    scl_in && $past(scl_in) && $rose(sda_in) |-> !sda_oe [*4];
  endproperty
  a_stop: assert property (p_stop) else $error("oe after stop");
  property p_rise;
    $rose(sda_oe) |-> !scl_in && ($past(scl_in, 2) || $past(scl_in, 3));
  endproperty
  a_rise: assert property (p_rise) else $error("oe rise late");
  property p_fall;
    $fell(sda_oe) |-> $past(scl_in, 2) || $past(scl_in, 3);
  endproperty
  a_fall: assert property (p_fall) else $error("oe fall late");
  property p_hold;
    $rose(sda_oe) |-> sda_oe [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("oe short");

  c_start: cover property (scl_in && $fell(sda_in));
  c_ack: cover property ($rose(sda_oe));
  c_cap: cover property (cap[0].stb ##1 cap[0].stb);
endmodule // vbd_bank_sva

bind vbd_bank vbd_bank_sva vbd_bank_sva_inst (.core_clk(core_clk), .rst(rst), .cap(cap),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// [testbench/tb_top.sv]
// Self-checking bench for the readback bank
`timescale 1ns/1ps
module tb_top
  import vbd_pkg::*;
;
  logic core_clk;
  logic rst;
  vbd_cap_t [VBD_SLOTS-1:0] cap;
  logic sda_out;
  logic sda_oe;
  logic scl;
  logic host_low;
  wire sda;
  int n_mismatch;
  int checks_done;
  int wd[VBD_SLOTS];
  int fpos[VBD_SLOTS] = '{6, 5, 4, 3, 0};
  int flg;
  logic [31:0] seed;

  assign sda = (sda_oe ? sda_out : 1'b1) & ~host_low;

  vbd_bank vbd_bank_inst (.core_clk(core_clk), .rst(rst), .cap(cap), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  vbd_host_model vbd_host_model_inst (.core_clk(core_clk), .sda(sda), .scl(scl),
    .sda_low(host_low));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected byte at a subaddress
  function automatic int expb(input int a);
    int s;
    int k;
    if (a == 8'h21)
      return flg;
    if (a < 8'h22 || a > 8'h2D)
      return 0;
    s = (a < 8'h26) ? (a - 8'h22) / 2 : (a < 8'h2C) ? 2 + (a - 8'h26) / 3 : 4;
    k = (a < 8'h26) ? (a - 8'h22) % 2 : (a < 8'h2C) ? (a - 8'h26) % 3 : a - 8'h2C;
    return (wd[s] >> (8 * k)) & 8'hFF;
  endfunction

  task automatic capt(input int s, input logic [19:0] w);
    for (int j = 0; j < VBD_SLOTS; j++)
      cap[j].stb = (j == s);
    cap[s].word = w;
    wd[s] = w & (s < 2 ? 20'h0FFFF : s < 4 ? 20'hFFFFF : 20'h01FFF);
    flg = flg | (1 << fpos[s]);
    @(negedge core_clk);
  endtask

  task automatic cap_off();
    for (int j = 0; j < VBD_SLOTS; j++)
      cap[j].stb = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic cmp(input string nm, input int e, input logic [7:0] g);
    checks_done++;
    if (g !== e[7:0])
    begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic head(input logic [7:0] a);
    logic [7:0] q;
    logic k;
    vbd_host_model_inst.start();
    vbd_host_model_inst.xb({VBD_DEV_ADDR, 1'b0}, 1'b1, q, k);
    cmp("addr ack", 0, {7'h00, k});
    vbd_host_model_inst.xb(a, 1'b1, q, k);
    cmp("sub ack", 0, {7'h00, k});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic k;
    head(a);
    vbd_host_model_inst.xb(d, 1'b1, q, k);
    cmp("data ack", 0, {7'h00, k});
    vbd_host_model_inst.stop();
    if (a == VBD_ADDR_FLAG_CLEAR)
      flg = flg & ~int'(d);
  endtask

  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] q;
    logic k;
    head(a);
    vbd_host_model_inst.start();
    vbd_host_model_inst.xb({VBD_DEV_ADDR, 1'b1}, 1'b1, q, k);
    cmp("read ack", 0, {7'h00, k});
    for (int i = 0; i < n; i++)
    begin
      vbd_host_model_inst.xb(8'hFF, i == n - 1, q, k);
      cmp("read byte", expb(a + i), q);
    end
    vbd_host_model_inst.stop();
  endtask

  // Frame for another device: no acknowledge, nothing acts
  task automatic nak();
    logic [7:0] q;
    logic k;
    vbd_host_model_inst.start();
    vbd_host_model_inst.xb({VBD_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, k);
    cmp("other addr nack", 1, {7'h00, k});
    vbd_host_model_inst.xb(VBD_ADDR_FLAG_CLEAR, 1'b1, q, k);
    vbd_host_model_inst.xb(8'hFF, 1'b1, q, k);
    cmp("other data nack", 1, {7'h00, k});
    vbd_host_model_inst.stop();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    cap = '0;
    seed = 32'h6C686A3C;
    flg = 0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    rd(VBD_ADDR_FLAGS, 1);
    $display("test reset done");
    for (int s = 0; s < 7; s++)
    begin
      seed = lfsr(seed);
      capt(s < 5 ? s : 0, seed[19:0]);
    end
    cap_off();
    rd(VBD_ADDR_CC_ODD_LO, 2);
    rd(VBD_ADDR_CC_EVEN_LO, 2);
    rd(VBD_ADDR_CG_ODD_B0, 3);
    rd(VBD_ADDR_CG_EVEN_B0, 3);
    rd(VBD_ADDR_WS_LO, 1);
    rd(VBD_ADDR_WS_HI, 1);
    rd(VBD_ADDR_FLAGS, 13);
    $display("test readback done");
    for (int a = 8'h22; a <= 8'h2D; a++)
    begin
      seed = lfsr(seed);
      wr(a[7:0], seed[7:0]);
    end
    rd(VBD_ADDR_FLAGS, 13);
    $display("test write ignored done");
    wr(VBD_ADDR_FLAG_CLEAR, 8'h50);
    rd(VBD_ADDR_FLAGS, 1);
    seed = lfsr(seed);
    capt(0, seed[19:0]);
    cap_off();
    wr(VBD_ADDR_FLAG_CLEAR, 8'h09);
    rd(VBD_ADDR_FLAGS, 3);
    $display("test flag clear done");
    seed = lfsr(seed);
    fork
      wr(VBD_ADDR_FLAG_CLEAR, 8'h40);
      begin
        // Start, two bytes, eight data bits, then one edge more
        repeat (16 + 2 * 76 + 8 * 8 + 1) @(negedge core_clk);
        capt(0, seed[19:0]);
        cap_off();
      end
    join
    // Capture in the clearing cycle wins
    flg = flg | (1 << fpos[0]);
    rd(VBD_ADDR_FLAGS, 3);
    $display("test clear collision done");
    nak();
    rd(VBD_ADDR_FLAGS, 1);
    wr(VBD_ADDR_FLAG_CLEAR, 8'hFF);
    rd(VBD_ADDR_FLAG_CLEAR, 3);
    $display("test foreign address and full clear done");
    report_and_stop();
  end
endmodule // tb_top
